//--- shared/lacl_pkg.sv
// constants, field layouts and types of the load-adaptive current learning block
// assumes a 32-bit apb register bus with byte addresses on paddr[7:0]
package lacl_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_CFG      = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_CONST    = 8'h0c;
	localparam logic [7:0] OFF_LIMITS   = 8'h10;
	localparam logic [7:0] OFF_ESTIMATE = 8'h14;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_TRIG_BIT  = 1;
	localparam int CTRL_COMP_BIT  = 2;
	localparam int STAT_DONE_BIT  = 0;
	localparam int STAT_BUSY_BIT  = 1;
	localparam int STAT_CUR_LSB   = 8;
	localparam int CONST_HIGH_LSB = 16;
	localparam int EST_BAND_LSB   = 16;

	// ---------------------------------------------------------------
	// reset values and learning arithmetic
	// ---------------------------------------------------------------
	localparam logic [8:0]  RST_CFG      = 9'h000;
	localparam logic [31:0] RST_LIMITS   = 32'h0000_ff00;
	localparam logic [10:0] RST_CONST    = 11'h000;
	localparam int          LEVEL_SHIFT  = 3;
	localparam logic [8:0]  INC_CODE0    = 9'h080;
	localparam logic [8:0]  INC_CODE1    = 9'h010;
	localparam logic [8:0]  INC_CODE2    = 9'h020;
	localparam logic [8:0]  INC_CODE3    = 9'h040;
	localparam logic [5:0]  DWELL_UNIT   = 6'h08;
	localparam logic [7:0]  LEVEL_MAX    = 8'hff;
	localparam logic [10:0] ESTIMATE_MAX = 11'h7ff;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] dwell;
		logic [1:0] incr;
		logic [4:0] base;
	} lacl_cfg_t;

	typedef struct packed {
		logic [7:0] band_lower;
		logic [7:0] band_upper;
		logic [7:0] ceiling;
		logic [7:0] floor;
	} lacl_limits_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_LOW    = 4'b0010,
		ST_HIGH   = 4'b0100,
		ST_FINISH = 4'b1000
	} lacl_state_t;
endpackage

//--- logic/lacl_zero_cross.sv
// half-cycle pulse generator from the coil current polarity pin
// assumes the polarity pin is asynchronous to pclk
`timescale 1ns/1ps
module lacl_zero_cross (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// coil polarity pin
	input  wire logic coil_positive,
	// one pulse per zero crossing
	output logic      half_cycle
);
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;

	// ---------------------------------------------------------------
	// synchroniser and edge detect
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end else begin
			sync1_reg <= coil_positive;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// RL21: crossing either way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cycle <= 1'b0;
		end else begin
			half_cycle <= sync2_reg ^ prev_reg;
		end
	end
endmodule

//--- logic/lacl_interp.sv
// fixed-loss interpolation and supply rescaling
// assumes all inputs come from logic on pclk; result lags inputs by one cycle
`timescale 1ns/1ps
module lacl_interp (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// learned points
	input  wire logic [10:0] const_low,
	input  wire logic [10:0] const_high,
	input  wire logic [8:0]  level_low,
	input  wire logic [8:0]  level_high,
	input  wire logic [7:0]  current,
	// supply compensation
	input  wire logic        comp_en,
	input  wire logic [7:0]  vm_ref,
	input  wire logic [7:0]  vm_now,
	input  wire logic [15:0] band_in,
	// results
	output logic      [10:0] estimate,
	output logic      [15:0] band_out
);
	logic signed [12:0] dy;
	logic signed [10:0] dx;
	logic signed [10:0] span;
	logic signed [24:0] lin;
	logic [10:0]        lin_sat;
	logic [18:0]        scaled;
	logic [15:0]        band_s;
	logic               comp_ok;

	// RL11: straight line through both points
	always_comb begin
		dy   = $signed({2'b00, const_high}) - $signed({2'b00, const_low});
		dx   = $signed({3'b000, current}) - $signed({2'b00, level_low});
		span = $signed({2'b00, level_high}) - $signed({2'b00, level_low});
		if (span == 11'sd0) begin
			lin = $signed({14'h0000, const_low});
		end else begin
			lin = $signed({14'h0000, const_low}) + (dy * dx) / span;
		end
		if (lin < 25'sd0) begin
			lin_sat = 11'h000;
		end else if (lin > $signed({14'h0000, lacl_pkg::ESTIMATE_MAX})) begin
			lin_sat = lacl_pkg::ESTIMATE_MAX;
		end else begin
			lin_sat = lin[10:0];
		end
	end

	// RL12: loss goes as 1/supply, limits follow the same ratio
	always_comb begin
		comp_ok = comp_en && (vm_now != 8'h00) && (vm_ref != 8'h00);
		scaled  = 19'((lin_sat * vm_ref) / vm_now);
		band_s[7:0]  = 8'(({8'h00, band_in[7:0]} * vm_ref) / vm_now);
		band_s[15:8] = 8'(({8'h00, band_in[15:8]} * vm_ref) / vm_now);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			estimate <= 11'h000;
			band_out <= 16'h0000;
		end else if (comp_ok) begin
			estimate <= (scaled > 19'(lacl_pkg::ESTIMATE_MAX)) ?
				lacl_pkg::ESTIMATE_MAX : scaled[10:0];
			band_out <= band_s;
		end else begin
			estimate <= lin_sat;
			band_out <= band_in;
		end
	end
endmodule

//--- logic/lacl_top.sv
// apb register file and learning sequencer for load-adaptive coil current
// assumes loss samples and supply level arrive from measurement logic on pclk,
// and the coil polarity pin is asynchronous
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps

// How it works
// RL1: enable bit switches the load-adaptive feature on.
// RL2: first learning level is base field times eight.
// RL3: second level is first level plus decoded increment.
// RL4: increment codes 0..3 give 128, 16, 32, 64 steps.
// RL5: dwell codes 0..3 give 8, 16, 24, 32 half-cycles.
// RL6: writing trigger starts learning; hardware clears it when finished.
// RL7: complete flag goes high when learning finishes.
// RL8: drive first level for dwell, then second level for dwell.
// RL9: loss at each level stored into eleven-bit low and high constants.
// RL10: after learning the current moves to the ceiling.
// RL11: loss at other currents is interpolated between the two constants.
// RL12: supply compensation rescales band limits and loss estimates.
// RL13: software keeps the second level at or below 255.
// RL14: software puts first level at 30 to 50 percent of maximum.
// RL15: trigger only unloaded and at steady speed.
// RL16: relearn after motor swap or ten percent speed change.
// RL17: software runs learning after enabling the feature.
// RL18: software enables, runs unloaded, programs fields, then triggers.
// RL19: production may program constants directly, then enable.
// RL20: while active, current stays between floor and ceiling; the learning levels are driven without this clamp.
// RL21: dwell counts coil zero crossings; triggers ignored while busy.
module lacl_top (
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// motor side
	input  wire logic        coil_positive,
	input  wire logic [10:0] loss_sample,
	input  wire logic        loss_sample_valid,
	input  wire logic [7:0]  vm_level,
	output logic      [7:0]  current_cmd,
	output logic             torque_adapt_active,
	output logic             learning_active,
	output logic      [10:0] fixed_loss_estimate
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic                 torque_adapt_enable_reg;
	logic                 learn_trigger_reg;
	logic                 supply_compensation_reg;
	logic                 learn_complete_reg;
	lacl_pkg::lacl_cfg_t  cfg_reg;
	lacl_pkg::lacl_limits_t limits_reg;
	logic [10:0]          loss_const_low_reg;
	logic [10:0]          loss_const_high_reg;
	logic [10:0]          last_sample_reg;
	logic [7:0]           vm_ref_reg;
	logic [5:0]           dwell_cnt_reg;
	lacl_pkg::lacl_state_t state_reg;
	lacl_pkg::lacl_state_t state_next;

	logic                 wr_en;
	logic                 rd_en;
	logic                 addr_ok;
	logic                 start_req;
	logic                 half_cycle;
	logic                 dwell_end;
	logic [8:0]           level_low;
	logic [8:0]           level_high;
	logic [8:0]           inc_steps;
	logic [5:0]           dwell_target;
	logic [10:0]          est_w;
	logic [15:0]          band_w;
	logic [31:0]          rd_mux;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	// pready is raised in the access phase from a flop, so every
	// transfer takes exactly setup plus one access cycle
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_comb begin
		case (paddr)
		lacl_pkg::OFF_CTRL,
		lacl_pkg::OFF_CFG,
		lacl_pkg::OFF_STATUS,
		lacl_pkg::OFF_CONST,
		lacl_pkg::OFF_LIMITS,
		lacl_pkg::OFF_ESTIMATE: addr_ok = 1'b1;
		default:                addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_adapt_enable_reg <= 1'b0;
			supply_compensation_reg <= 1'b0;
			cfg_reg                 <= lacl_pkg::RST_CFG;
			limits_reg              <= lacl_pkg::RST_LIMITS;
		end else if (wr_en) begin
			case (paddr)
			lacl_pkg::OFF_CTRL: begin
				// RL1: feature enable
				torque_adapt_enable_reg <= pwdata[lacl_pkg::CTRL_EN_BIT];
				// RL12: compensation select
				supply_compensation_reg <= pwdata[lacl_pkg::CTRL_COMP_BIT];
			end
			lacl_pkg::OFF_CFG: begin
				// fields shift under a running routine on the cycle after the write, not only at level entry
				cfg_reg <= pwdata[8:0];
			end
			lacl_pkg::OFF_LIMITS: begin
				limits_reg <= pwdata;
			end
			default: begin
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// learning levels
	// ---------------------------------------------------------------
	// RL4: increment decode
	always_comb begin
		case (cfg_reg.incr)
		2'b00:   inc_steps = lacl_pkg::INC_CODE0;
		2'b01:   inc_steps = lacl_pkg::INC_CODE1;
		2'b10:   inc_steps = lacl_pkg::INC_CODE2;
		default: inc_steps = lacl_pkg::INC_CODE3;
		endcase
	end

	// RL2: base times eight
	assign level_low = 9'(cfg_reg.base) << lacl_pkg::LEVEL_SHIFT;
	// RL3: second level on top of the first
	assign level_high = level_low + inc_steps;
	// RL5: dwell of 8, 16, 24 or 32 half-cycles
	assign dwell_target = 6'(({4'h0, cfg_reg.dwell} + 6'h01) * lacl_pkg::DWELL_UNIT);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// RL6: trigger write; RL21: ignored while busy or when the same write clears the enable bit
	assign start_req = wr_en && (paddr == lacl_pkg::OFF_CTRL)
		&& pwdata[lacl_pkg::CTRL_TRIG_BIT] && (state_reg == lacl_pkg::ST_IDLE)
		&& pwdata[lacl_pkg::CTRL_EN_BIT];
	assign dwell_end = half_cycle && (dwell_cnt_reg == dwell_target - 6'h01);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		lacl_pkg::ST_IDLE: begin
			if (start_req) begin
				state_next = lacl_pkg::ST_LOW;
			end
		end
		lacl_pkg::ST_LOW: begin
			if (!torque_adapt_enable_reg) begin
				state_next = lacl_pkg::ST_IDLE;
			end else if (dwell_end) begin
				state_next = lacl_pkg::ST_HIGH;
			end
		end
		lacl_pkg::ST_HIGH: begin
			if (!torque_adapt_enable_reg) begin
				state_next = lacl_pkg::ST_IDLE;
			end else if (dwell_end) begin
				state_next = lacl_pkg::ST_FINISH;
			end
		end
		lacl_pkg::ST_FINISH: begin
			state_next = lacl_pkg::ST_IDLE;
		end
		default: begin
			state_next = lacl_pkg::ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= lacl_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// RL21: half-cycles counted per level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dwell_cnt_reg <= 6'h00;
		end else if (state_reg != state_next || state_reg == lacl_pkg::ST_IDLE) begin
			dwell_cnt_reg <= 6'h00;
		end else if (half_cycle) begin
			dwell_cnt_reg <= dwell_cnt_reg + 6'h01;
		end
	end

	// RL6: trigger set by software, cleared by hardware at the end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			learn_trigger_reg <= 1'b0;
		end else if (start_req) begin
			learn_trigger_reg <= 1'b1;
		end else if (state_next == lacl_pkg::ST_IDLE) begin
			learn_trigger_reg <= 1'b0;
		end
	end

	// RL7: completion flag, dropped when a new run starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			learn_complete_reg <= 1'b0;
		end else if (state_reg == lacl_pkg::ST_FINISH) begin
			learn_complete_reg <= 1'b1;
		end else if (start_req) begin
			learn_complete_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// loss capture
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_sample_reg <= 11'h000;
		end else if (loss_sample_valid) begin
			last_sample_reg <= loss_sample;
		end
	end

	// RL9: hardware capture wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_const_low_reg  <= lacl_pkg::RST_CONST;
			loss_const_high_reg <= lacl_pkg::RST_CONST;
		end else if (state_reg == lacl_pkg::ST_LOW && dwell_end) begin
			loss_const_low_reg <= last_sample_reg;
		end else if (state_reg == lacl_pkg::ST_HIGH && dwell_end) begin
			loss_const_high_reg <= last_sample_reg;
		end else if (wr_en && paddr == lacl_pkg::OFF_CONST) begin
			loss_const_low_reg  <= pwdata[10:0];
			loss_const_high_reg <= pwdata[lacl_pkg::CONST_HIGH_LSB +: 11];
		end
	end

	// RL12: supply level at learning end, or when compensation is switched on, is the scaling reference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vm_ref_reg <= 8'h00;
		end else if (state_reg == lacl_pkg::ST_FINISH) begin
			vm_ref_reg <= vm_level;
		end else if (wr_en && paddr == lacl_pkg::OFF_CTRL
			&& pwdata[lacl_pkg::CTRL_COMP_BIT] && !supply_compensation_reg) begin
			vm_ref_reg <= vm_level;
		end
	end

	// ---------------------------------------------------------------
	// current command
	// ---------------------------------------------------------------
	// second level saturates; software keeps it in range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_cmd <= lacl_pkg::LEVEL_MAX;
		end else begin
			case (state_next)
			// RL8: first level
			lacl_pkg::ST_LOW:  current_cmd <= level_low[7:0];
			// RL8: second level; RL13: clipped
			lacl_pkg::ST_HIGH: current_cmd <= level_high[8] ?
				lacl_pkg::LEVEL_MAX : level_high[7:0];
			// RL10: ceiling after learning
			lacl_pkg::ST_FINISH: current_cmd <= limits_reg.ceiling;
			default: begin
				// RL20: hold inside floor and ceiling
				if (!torque_adapt_enable_reg) begin
					current_cmd <= current_cmd;
				end else if (current_cmd > limits_reg.ceiling) begin
					current_cmd <= limits_reg.ceiling;
				end else if (current_cmd < limits_reg.floor) begin
					current_cmd <= limits_reg.floor;
				end
			end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_adapt_active <= 1'b0;
			learning_active     <= 1'b0;
			fixed_loss_estimate <= 11'h000;
		end else begin
			torque_adapt_active <= torque_adapt_enable_reg;
			learning_active     <= state_next == lacl_pkg::ST_LOW
				|| state_next == lacl_pkg::ST_HIGH;
			fixed_loss_estimate <= est_w;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
		lacl_pkg::OFF_CTRL: begin
			rd_mux[lacl_pkg::CTRL_EN_BIT]   = torque_adapt_enable_reg;
			rd_mux[lacl_pkg::CTRL_TRIG_BIT] = learn_trigger_reg;
			rd_mux[lacl_pkg::CTRL_COMP_BIT] = supply_compensation_reg;
		end
		lacl_pkg::OFF_CFG:    rd_mux[8:0] = cfg_reg;
		lacl_pkg::OFF_STATUS: begin
			rd_mux[lacl_pkg::STAT_DONE_BIT] = learn_complete_reg;
			rd_mux[lacl_pkg::STAT_BUSY_BIT] = learn_trigger_reg;
			rd_mux[lacl_pkg::STAT_CUR_LSB +: 8] = current_cmd;
		end
		lacl_pkg::OFF_CONST: begin
			rd_mux[10:0] = loss_const_low_reg;
			rd_mux[lacl_pkg::CONST_HIGH_LSB +: 11] = loss_const_high_reg;
		end
		lacl_pkg::OFF_LIMITS: rd_mux = limits_reg;
		lacl_pkg::OFF_ESTIMATE: begin
			rd_mux[10:0] = est_w;
			rd_mux[lacl_pkg::EST_BAND_LSB +: 16] = band_w;
		end
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	lacl_zero_cross u_zero_cross (
		.pclk          (pclk),
		.presetn       (presetn),
		.coil_positive (coil_positive),
		.half_cycle    (half_cycle)
	);

	lacl_interp u_interp (
		.pclk       (pclk),
		.presetn    (presetn),
		.const_low  (loss_const_low_reg),
		.const_high (loss_const_high_reg),
		.level_low  (level_low),
		.level_high (level_high),
		.current    (current_cmd),
		.comp_en    (supply_compensation_reg),
		.vm_ref     (vm_ref_reg),
		.vm_now     (vm_level),
		.band_in    ({limits_reg.band_lower, limits_reg.band_upper}),
		.estimate   (est_w),
		.band_out   (band_w)
	);
endmodule

//--- verif/lacl_checker.sv
// concurrent checks of the learning block, seeing only its top ports
// assumes one clock domain and a coil current that keeps turning
`timescale 1ns/1ps
module lacl_checker (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// motor side
	input wire logic        coil_positive,
	input wire logic [7:0]  current_cmd,
	input wire logic        torque_adapt_active,
	input wire logic        learning_active
);
	// ----
	// shadow of the level fields
	// ----
	lacl_pkg::lacl_cfg_t cfg_reg;
	logic                acc;
	logic [8:0]          lvl1;
	logic [8:0]          lvl2;
	logic [8:0]          inc;
	logic [5:0]          dwell_n;
	logic [5:0]          half_cnt;
	logic                coil_reg;
	logic [7:0]          cur_reg;
	assign acc = psel && penable && pready && pwrite;
	assign lvl1 = {1'b0, cfg_reg.base, 3'h0};
	assign lvl2 = (lvl1 + inc > 9'h0ff) ? 9'h0ff : lvl1 + inc;
	assign dwell_n = ({4'h0, cfg_reg.dwell} + 6'h01) * 6'h08;
	always_comb begin
		case (cfg_reg.incr)
			2'h0: inc = 9'h080;
			2'h1: inc = 9'h010;
			2'h2: inc = 9'h020;
			default: inc = 9'h040;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
		end else if (acc && paddr == lacl_pkg::OFF_CFG) begin
			cfg_reg <= pwdata[8:0];
		end
	end
	// half-cycles seen since the current last moved; cleared outside learning
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= 6'h00;
			coil_reg <= 1'b0;
			cur_reg  <= 8'hff;
		end else begin
			coil_reg <= coil_positive;
			cur_reg  <= current_cmd;
			if (!learning_active || current_cmd != cur_reg) begin
				half_cnt <= 6'h00;
			end else if (coil_positive != coil_reg) begin
				half_cnt <= half_cnt + 6'h01;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// properties
	// ----
	property p_ready_access;
		psel && !penable |=> pready;
	endproperty
	a_ready_access: assert property (p_ready_access) else $error("no answer in access");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready too long");
	property p_unmapped;
		pready && paddr > 8'h14 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_enable_copy;
		acc && paddr == lacl_pkg::OFF_CTRL |-> ##2 torque_adapt_active == $past(pwdata[0], 2);
	endproperty
	a_enable_copy: assert property (p_enable_copy) else $error("enable not followed");
	property p_first_level;
		$rose(learning_active) |-> current_cmd == lvl1[7:0];
	endproperty
	a_first_level: assert property (p_first_level) else $error("first level wrong");
	property p_second_level;
		learning_active && $past(learning_active) && $changed(current_cmd)
			|-> current_cmd == lvl2[7:0];
	endproperty
	a_second_level: assert property (p_second_level) else $error("second level wrong");
	property p_dwell;
		$fell(learning_active) |-> half_cnt == dwell_n;
	endproperty
	a_dwell: assert property (p_dwell) else $error("dwell count wrong");
	property p_hold;
		$rose(learning_active) |-> learning_active [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("learning dropped early");
endmodule

//--- verif/lacl_motor_model.sv
// unloaded motor: coil polarity toggles each half-cycle, loss tracks current
// assumes current_cmd comes from the block on pclk
`timescale 1ns/1ps
module lacl_motor_model #(
	parameter int HALF = 20
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// drive and feedback
	input wire logic [7:0]  current_cmd,
	output logic            coil_positive,
	output logic [10:0]     loss_sample,
	output logic            loss_sample_valid,
	output logic [7:0]      vm_level
);
	int cnt;
	assign vm_level = 8'h80;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt               <= 0;
			coil_positive     <= 1'b0;
			loss_sample       <= 11'h000;
			loss_sample_valid <= 1'b0;
		end else begin
			loss_sample_valid <= cnt == HALF - 1;
			if (cnt == HALF - 1) begin
				cnt           <= 0;
				coil_positive <= !coil_positive;
				loss_sample   <= {current_cmd, 3'h0};
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

//--- verif/testbench.sv
// self-checking bench: apb master tasks, motor model, one task per scenario
// assumes checker and motor model are compiled before this file
`timescale 1ns/1ps
module testbench;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        coil_positive;
	logic [10:0] loss_sample;
	logic        loss_sample_valid;
	logic [7:0]  vm_level;
	logic [7:0]  current_cmd;
	logic        torque_adapt_active;
	logic        learning_active;
	logic [10:0] fixed_loss_estimate;
	logic [31:0] rd;
	logic        er;
	logic [8:0]  step [4] = '{9'h080, 9'h010, 9'h020, 9'h040};
	int          bad_count;
	int          comparisons;
	int          cyc;
	always #5 pclk = ~pclk;
	lacl_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .coil_positive(coil_positive), .loss_sample(loss_sample),
		.loss_sample_valid(loss_sample_valid), .vm_level(vm_level),
		.current_cmd(current_cmd), .torque_adapt_active(torque_adapt_active),
		.learning_active(learning_active), .fixed_loss_estimate(fixed_loss_estimate)
	);
	lacl_motor_model i_motor (
		.pclk(pclk), .presetn(presetn), .current_cmd(current_cmd),
		.coil_positive(coil_positive), .loss_sample(loss_sample),
		.loss_sample_valid(loss_sample_valid), .vm_level(vm_level)
	);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic t_reset();
		chk("current reset", 32'h0ff, 32'(current_cmd));
		apb(1'b0, lacl_pkg::OFF_LIMITS, 32'h0);
		chk("limits reset", 32'h0000_ff00, rd);
		apb(1'b0, lacl_pkg::OFF_CONST, 32'h0);
		chk("constants reset", 32'h0, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, 32'(er));
		apb(1'b1, lacl_pkg::OFF_LIMITS, 32'h0000_c000);
	endtask
	task automatic t_learn(input logic [4:0] b, input logic [1:0] n, input logic [1:0] d);
		logic [8:0] l1;
		logic [8:0] l2;
		l1 = {1'b0, b, 3'h0};
		l2 = l1 + step[n];
		apb(1'b1, lacl_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, lacl_pkg::OFF_CFG, {23'h0, d, n, b});
		apb(1'b1, lacl_pkg::OFF_CTRL, 32'h3);
		@(negedge pclk);
		chk("first level", 32'(l1), 32'(current_cmd));
		while (current_cmd === l1[7:0]) @(negedge pclk);
		chk("second level", 32'(l2), 32'(current_cmd));
		// retrigger while busy must be ignored
		apb(1'b1, lacl_pkg::OFF_CTRL, 32'h3);
		while (learning_active === 1'b1) @(negedge pclk);
		chk("ceiling", 32'h0c0, 32'(current_cmd));
		apb(1'b0, lacl_pkg::OFF_STATUS, 32'h0);
		chk("complete", 32'h1, 32'(rd[1:0]));
		apb(1'b0, lacl_pkg::OFF_CTRL, 32'h0);
		chk("trigger", 32'h1, 32'(rd[1:0]));
		apb(1'b0, lacl_pkg::OFF_CONST, 32'h0);
		chk("constants", {5'h0, l2[7:0], 3'h0, 5'h0, l1[7:0], 3'h0}, rd);
		chk("estimate", 32'h600, 32'(fixed_loss_estimate));
	endtask
	task automatic t_clamp();
		apb(1'b1, lacl_pkg::OFF_LIMITS, 32'h0000_9000);
		repeat (2) @(negedge pclk);
		chk("clamped", 32'h090, 32'(current_cmd));
		apb(1'b1, lacl_pkg::OFF_CTRL, 32'h0);
		repeat (2) @(negedge pclk);
		chk("disabled", 32'h0, 32'(torque_adapt_active));
	endtask
	task automatic t_prod();
		apb(1'b1, lacl_pkg::OFF_CONST, 32'h0540_0340);
		apb(1'b1, lacl_pkg::OFF_LIMITS, 32'h0000_c0a0);
		apb(1'b1, lacl_pkg::OFF_CTRL, 32'h1);
		repeat (2) @(negedge pclk);
		chk("floor", 32'h0a0, 32'(current_cmd));
		apb(1'b0, lacl_pkg::OFF_ESTIMATE, 32'h0);
		chk("estimate read", 32'h500, 32'(rd[10:0]));
	endtask
	// bounds a hang; the full run needs under 6000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		// first level 31 to 41 percent of full scale; relearn per change
		for (int i = 0; i < 4; i++) begin
			t_learn(5'(10 + i), 2'(i), 2'(i));
		end
		t_clamp();
		t_prod();
		conclude();
	end
endmodule
bind lacl_top lacl_checker i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.coil_positive(coil_positive), .current_cmd(current_cmd),
	.torque_adapt_active(torque_adapt_active), .learning_active(learning_active)
);
